//--- parallel_host_bus_port_bench.sv
// Bench: host end and device end joined by the pin bundle, judged at both user sides.
// Assumes one 200 MHz clock and a synchronous active-low reset for both ends.
`timescale 1ns/1ps
`default_nettype none
`include "phbp_defines.svh"

module parallel_host_bus_port_bench;
    import phbp_pkg::*;
    logic core_clk, rst_b, req, req_write, idle, done, wr_evt, act, act_q, cur_w, last_w;
    phbp_mode_t strap, mode, mode_sel;
    phbp_addr_t req_addr, wr_addr, a_hold;
    phbp_data_t req_wdata, rdata, wr_data, wd_exp;
    int error_cnt = 0;
    int checks = 0;
    int evt_n = 0;
    int gap = 0;

    // ****
    // Both ends and the checker
    // ****
    phbp_if bus ();
    phbp_dev phbp_dev_i (.core_clk(core_clk), .rst_b(rst_b), .bus(bus.dev),
        .bus_personality_strap(strap), .mode(mode), .wr_evt(wr_evt),
        .wr_addr(wr_addr), .wr_data(wr_data));
    phbp_host phbp_host_i (.core_clk(core_clk), .rst_b(rst_b), .bus(bus.host),
        .mode_sel(mode_sel), .req(req), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .idle(idle), .done(done), .rdata(rdata));
    phbp_sva phbp_sva_i (.core_clk(core_clk), .rst_b(rst_b),
        .chip_select_n(bus.chip_select_n), .write_strobe_n(bus.write_strobe_n),
        .read_strobe_n(bus.read_strobe_n), .data_h2d_oe(bus.data_h2d_oe),
        .data_d2h_oe(bus.data_d2h_oe), .transfer_acknowledge(bus.transfer_acknowledge),
        .transfer_acknowledge_oe(bus.transfer_acknowledge_oe));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ****
    // Compare and closing tasks
    // ****
    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic chk_min(input int got, input int lim);
        checks++;
        if (got < lim) begin
            error_cnt++;
            $display("Error at %0t: got %0h below %0h", $time, got, lim);
        end
    endtask

    task automatic give_verdict;
        if (error_cnt == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ****
    // Bus helpers
    // ****
    task automatic do_reset(input phbp_mode_t s);
        @(posedge core_clk);
        rst_b <= 1'b0;
        strap <= s;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic set_sel(input phbp_mode_t m);
        @(posedge core_clk);
        mode_sel <= m;
    endtask

    // One access; the host only takes a request while idle
    task automatic do_acc(input logic w, input phbp_addr_t a, input phbp_data_t d);
        int n;
        n = 0;
        while (idle !== 1'b1) begin
            @(posedge core_clk);
            #1;
        end
        @(posedge core_clk);
        req <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        wd_exp = d;
        @(posedge core_clk);
        req <= 1'b0;
        while (done !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk_min(400 - n, 1);
    endtask

    task automatic wr_chk(input phbp_addr_t a, input phbp_data_t d);
        int n0;
        n0 = evt_n;
        do_acc(1'b1, a, d);
        repeat (8) @(posedge core_clk);
        #1;
        chk_val(8'(evt_n - n0), 8'h01);
        chk_val({1'b0, wr_addr}, {1'b0, a});
        chk_val(wr_data, d);
    endtask

    task automatic rd_chk(input phbp_addr_t a, input phbp_data_t e);
        do_acc(1'b0, a, 8'h00);
        chk_val(rdata, e);
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_strap;
        do_reset(`PHBP_MODE_SEP);
        chk_val({5'h00, mode}, 8'h03);
        set_sel(`PHBP_MODE_SEP);
        rd_chk(`PHBP_MODE_ADDR, 8'h03);
        do_reset(`PHBP_MODE_SEL);
        chk_val({5'h00, mode}, 8'h04);
        set_sel(`PHBP_MODE_SEL);
    endtask

    // Boundary addresses and data, write then read back to back
    task automatic t_sel_rw;
        wr_chk(7'h7E, 8'hFF);
        rd_chk(7'h7E, 8'hFF);
        wr_chk(7'h00, 8'h5A);
        wr_chk(7'h01, 8'hA5);
        rd_chk(7'h00, 8'h5A);
        rd_chk(7'h01, 8'hA5);
    endtask

    // Personality switched by register write, in both directions
    task automatic t_mode_reg;
        wr_chk(`PHBP_MODE_ADDR, 8'h03);
        chk_val({5'h00, mode}, 8'h03);
        set_sel(`PHBP_MODE_SEP);
        wr_chk(7'h11, 8'hC3);
        rd_chk(7'h11, 8'hC3);
        rd_chk(7'h01, 8'hA5);
        wr_chk(`PHBP_MODE_ADDR, 8'h04);
        chk_val({5'h00, mode}, 8'h04);
        set_sel(`PHBP_MODE_SEL);
        rd_chk(7'h11, 8'hC3);
    endtask

    // Committed writes seen by the device user side
    always @(posedge core_clk) begin
        if (wr_evt === 1'b1) evt_n++;
    end

    // Wire watch: address hold, write data at access end, spacing of accesses
    always @(posedge core_clk) begin
        act = (mode_sel == `PHBP_MODE_SEP) ? !(bus.read_strobe_n && bus.write_strobe_n)
            : !bus.chip_select_n;
        if (rst_b !== 1'b1) begin
            gap = 99;
            act_q = 1'b0;
            cur_w = 1'b0;
            last_w = 1'b0;
        end else begin
            if (act && !act_q) begin
                chk_min(gap, last_w ? 32 : 3);
                a_hold = bus.addr;
                cur_w = 1'b0;
            end
            if (act && !bus.write_strobe_n) cur_w = 1'b1;
            if (!act && act_q) begin
                chk_val({1'b0, bus.addr}, {1'b0, a_hold});
                if (cur_w) chk_val(bus.data_bus, wd_exp);
                last_w = cur_w;
            end
            gap = act ? 0 : gap + 1;
            act_q = act;
        end
    end

    // Watchdog: the sequence needs only a few hundred cycles
    initial begin
        #100000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        rst_b = 1'b0;
        strap = `PHBP_MODE_SEL;
        mode_sel = `PHBP_MODE_SEL;
        req = 1'b0;
        req_write = 1'b0;
        req_addr = 7'h00;
        req_wdata = 8'h00;
        wd_exp = 8'h00;
        t_strap();
        t_sel_rw();
        t_mode_reg();
        give_verdict();
    end
endmodule

`default_nettype wire

//--- phbp_defines.svh
// Constants of the parallel host bus port: widths, codes, addresses and timing counts.
// Assumes a 200 MHz core clock; every count is derived from a time in ns.
`ifndef PHBP_DEFINES_SVH
`define PHBP_DEFINES_SVH

// ****************************************
// Widths and codes
// ****************************************
`define PHBP_ADDR_W 7
`define PHBP_DATA_W 8
`define PHBP_MODE_W 3
`define PHBP_MODE_SEL 3'h4
`define PHBP_MODE_SEP 3'h3
`define PHBP_MODE_ADDR 7'h7F

// ****************************************
// Timing in ns and derived cycle counts
// ****************************************
`define PHBP_CLK_NS 5
`define PHBP_CEIL_CYC(ns) (((ns) + `PHBP_CLK_NS - 1) / `PHBP_CLK_NS)
`define PHBP_FLOOR_CYC(ns) ((ns) / `PHBP_CLK_NS)
`define PHBP_RD_ACCESS_NS 20
`define PHBP_WR_ACCESS_NS 20
`define PHBP_WR_COMMIT_NS 120
`define PHBP_RD_CYC `PHBP_CEIL_CYC(`PHBP_RD_ACCESS_NS)
`define PHBP_WR_CYC `PHBP_CEIL_CYC(`PHBP_WR_ACCESS_NS)
`define PHBP_COMMIT_CYC `PHBP_CEIL_CYC(`PHBP_WR_COMMIT_NS)
`define PHBP_SEL_RR_MAX_NS 49
`define PHBP_SEL_WR_MAX_NS 182
`define PHBP_SEL_W_MAX_NS 166
`define PHBP_SEP_RR_MAX_NS 45
`define PHBP_SEP_WR_MAX_NS 182
`define PHBP_SEL_RR_MAX_CYC `PHBP_FLOOR_CYC(`PHBP_SEL_RR_MAX_NS)
`define PHBP_SEP_RR_MAX_CYC `PHBP_FLOOR_CYC(`PHBP_SEP_RR_MAX_NS)
`define PHBP_GAP_WR_NS 160
`define PHBP_GAP_RD_NS 15
`define PHBP_GAP_WR_CYC `PHBP_CEIL_CYC(`PHBP_GAP_WR_NS)
`define PHBP_GAP_RD_CYC `PHBP_CEIL_CYC(`PHBP_GAP_RD_NS)

`endif

//--- phbp_dev.sv
// Device end of the parallel host bus port: register file behind a select-strobed
// or separate-strobe bus, with a ready handshake that stretches each access.
// Assumes host strobes are asynchronous to core_clk and the host keeps its own timing.
// Functional notes
// - Strap code picks personality: 100 or 011
// - Write to address 7F changes personality
// - Select mode: separate address and data buses
// - Host sets direction and address before select
// - Select mode: ready high, low at completion
// - Select read stretch: 49 ns, 182 after write
// - Write data captured at end of select
// - Host gap 160 ns after write, 15 reads
// - Separate mode: distinct read, write strobes
// - Separate mode: ready low until data ready
// - Separate read stretch: 45 ns, 182 after write
// - Host holds select and address past strobe
// - Host strobe gap 160 after write, 15 reads
`timescale 1ns/1ps
`default_nettype none
`include "phbp_defines.svh"

module phbp_dev (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Host pins
    phbp_if.dev bus,
    // Power-up strap
    input wire phbp_pkg::phbp_mode_t bus_personality_strap,
    // User side
    output phbp_pkg::phbp_mode_t mode,
    output logic wr_evt,
    output phbp_pkg::phbp_addr_t wr_addr,
    output phbp_pkg::phbp_data_t wr_data
);
    import phbp_pkg::*;

    // ****************************************
    // Synchronisers
    // ****************************************
    logic cs_s1_r, cs_s2_r, rd_s1_r, rd_s2_r, wr_s1_r, wr_s2_r;
    phbp_data_t dat_p1_r, dat_p2_r;

    // Two flops per strobe; data is delayed alike so it lines up with the strobes
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            rd_s1_r <= 1'b1;
            rd_s2_r <= 1'b1;
            wr_s1_r <= 1'b1;
            wr_s2_r <= 1'b1;
            dat_p1_r <= '0;
            dat_p2_r <= '0;
        end else begin
            cs_s1_r <= bus.chip_select_n;
            cs_s2_r <= cs_s1_r;
            rd_s1_r <= bus.read_strobe_n;
            rd_s2_r <= rd_s1_r;
            wr_s1_r <= bus.write_strobe_n;
            wr_s2_r <= wr_s1_r;
            dat_p1_r <= bus.data_bus;
            dat_p2_r <= dat_p1_r;
        end
    end

    logic cs_act, rd_act, wr_act;
    assign cs_act = ~cs_s2_r;
    assign rd_act = ~rd_s2_r;
    assign wr_act = ~wr_s2_r;

    // ****************************************
    // Register file
    // ****************************************
    phbp_data_t mem [0:(1<<`PHBP_ADDR_W)-1];

    // Address 7F reads back the live personality rather than the array
    function automatic phbp_data_t read_word(input phbp_addr_t a, input phbp_mode_t m);
        phbp_data_t w;
        w = mem[a];
        if (a == `PHBP_MODE_ADDR) begin
            w = {{(`PHBP_DATA_W-`PHBP_MODE_W){1'b0}}, m};
        end
        return w;
    endfunction

    // ****************************************
    // Access state machine
    // ****************************************
    phbp_dev_state_t state_r, state_nxt;
    phbp_mode_t mode_r, mode_nxt;
    logic strap_done_r, strap_done_nxt;
    phbp_addr_t addr_r, addr_nxt;
    logic is_wr_r, is_wr_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [4:0] wbusy_r, wbusy_nxt;
    logic ack_r, ack_nxt, ack_oe_r, ack_oe_nxt;
    phbp_data_t dout_r, dout_nxt;
    logic dout_oe_r, dout_oe_nxt;
    logic wr_evt_r, wr_evt_nxt;
    phbp_addr_t wr_addr_r, wr_addr_nxt;
    phbp_data_t wr_data_r, wr_data_nxt;
    logic sel, sep, commit;

    // Next-state logic for both personalities
    always_comb begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        strap_done_nxt = 1'b1;
        addr_nxt = addr_r;
        is_wr_nxt = is_wr_r;
        cnt_nxt = cnt_r;
        wbusy_nxt = (wbusy_r != 5'h00) ? wbusy_r - 5'h01 : 5'h00;
        ack_nxt = ack_r;
        ack_oe_nxt = ack_oe_r;
        dout_nxt = dout_r;
        dout_oe_nxt = dout_oe_r;
        commit = 1'b0;
        sel = (mode_r == `PHBP_MODE_SEL);
        sep = (mode_r == `PHBP_MODE_SEP);
        // Strap is caught on the first clock after reset release
        if (!strap_done_r) begin
            mode_nxt = bus_personality_strap;
        end
        unique case (state_r)
            D_IDLE: begin
                ack_oe_nxt = 1'b0;
                dout_oe_nxt = 1'b0;
                if (sel && cs_act) begin
                    addr_nxt = bus.addr;
                    is_wr_nxt = wr_act;
                    cnt_nxt = wr_act ? 3'(`PHBP_WR_CYC) : 3'(`PHBP_RD_CYC);
                    ack_oe_nxt = 1'b1;
                    ack_nxt = 1'b1;
                    state_nxt = D_WAIT;
                end else if (sep && cs_act) begin
                    ack_oe_nxt = 1'b1;
                    ack_nxt = 1'b1;
                    state_nxt = D_ARMED;
                end
            end
            D_ARMED: begin
                if (!cs_act) begin
                    ack_oe_nxt = 1'b0;
                    state_nxt = D_IDLE;
                end else if (rd_act || wr_act) begin
                    addr_nxt = bus.addr;
                    is_wr_nxt = wr_act;
                    cnt_nxt = wr_act ? 3'(`PHBP_WR_CYC) : 3'(`PHBP_RD_CYC);
                    ack_nxt = 1'b0;
                    state_nxt = D_WAIT;
                end
            end
            D_WAIT: begin
                // A read waits out any write still settling into the array
                if (cnt_r != 3'h0) begin
                    cnt_nxt = cnt_r - 3'h1;
                end else if (is_wr_r || wbusy_r == 5'h00) begin
                    if (!is_wr_r) begin
                        dout_nxt = read_word(addr_r, mode_r);
                        dout_oe_nxt = 1'b1;
                    end
                    ack_nxt = sep;
                    state_nxt = D_HOLD;
                end
            end
            D_HOLD: begin
                if (sel && !cs_act) begin
                    commit = is_wr_r;
                    ack_oe_nxt = 1'b0;
                    dout_oe_nxt = 1'b0;
                    state_nxt = D_IDLE;
                end else if (!sel && !rd_act && !wr_act) begin
                    commit = is_wr_r;
                    dout_oe_nxt = 1'b0;
                    state_nxt = D_ARMED;
                end
            end
            default: state_nxt = D_IDLE;
        endcase
        if (commit) begin
            wbusy_nxt = 5'(`PHBP_COMMIT_CYC);
            if (addr_r == `PHBP_MODE_ADDR) begin
                mode_nxt = dat_p2_r[`PHBP_MODE_W-1:0];
            end
        end
        wr_evt_nxt = commit;
        wr_addr_nxt = commit ? addr_r : wr_addr_r;
        wr_data_nxt = commit ? dat_p2_r : wr_data_r;
    end

    // State registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r <= D_IDLE;
            mode_r <= '0;
            strap_done_r <= 1'b0;
            addr_r <= '0;
            is_wr_r <= 1'b0;
            cnt_r <= 3'h0;
            wbusy_r <= 5'h00;
            ack_r <= 1'b0;
            ack_oe_r <= 1'b0;
            dout_r <= '0;
            dout_oe_r <= 1'b0;
            wr_evt_r <= 1'b0;
            wr_addr_r <= '0;
            wr_data_r <= '0;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            strap_done_r <= strap_done_nxt;
            addr_r <= addr_nxt;
            is_wr_r <= is_wr_nxt;
            cnt_r <= cnt_nxt;
            wbusy_r <= wbusy_nxt;
            ack_r <= ack_nxt;
            ack_oe_r <= ack_oe_nxt;
            dout_r <= dout_nxt;
            dout_oe_r <= dout_oe_nxt;
            wr_evt_r <= wr_evt_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
        end
    end

    // Array store; no reset, contents are undefined until written
    always_ff @(posedge core_clk) begin
        if (commit) begin
            mem[addr_r] <= dat_p2_r;
        end
    end

    // Outputs straight from flops
    assign bus.transfer_acknowledge = ack_r;
    assign bus.transfer_acknowledge_oe = ack_oe_r;
    assign bus.data_d2h = dout_r;
    assign bus.data_d2h_oe = dout_oe_r;
    assign mode = mode_r;
    assign wr_evt = wr_evt_r;
    assign wr_addr = wr_addr_r;
    assign wr_data = wr_data_r;
endmodule

`default_nettype wire

//--- phbp_host.sv
// Host end of the parallel host bus port: turns one user request into one bus access.
// Assumes the ready line is pulled high when the device does not drive it.
`timescale 1ns/1ps
`default_nettype none
`include "phbp_defines.svh"

module phbp_host (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Host pins
    phbp_if.host bus,
    // User side
    input wire phbp_pkg::phbp_mode_t mode_sel,
    input wire logic req,
    input wire logic req_write,
    input wire phbp_pkg::phbp_addr_t req_addr,
    input wire phbp_pkg::phbp_data_t req_wdata,
    output logic idle,
    output logic done,
    output phbp_pkg::phbp_data_t rdata
);
    import phbp_pkg::*;

    // ****************************************
    // Access sequencer
    // ****************************************
    phbp_host_state_t state_r, state_nxt;
    logic cs_n_r, cs_n_nxt, wr_n_r, wr_n_nxt, rd_n_r, rd_n_nxt;
    phbp_addr_t addr_r, addr_nxt;
    phbp_data_t wd_r, wd_nxt, rdata_r, rdata_nxt;
    logic doe_r, doe_nxt, is_wr_r, is_wr_nxt, seen_r, seen_nxt, done_r, done_nxt;
    logic sep_r, sep_nxt;
    logic [5:0] gap_r, gap_nxt;

    // Ready waits high in select mode and low in separate mode
    always_comb begin
        state_nxt = state_r;
        cs_n_nxt = cs_n_r;
        wr_n_nxt = wr_n_r;
        rd_n_nxt = rd_n_r;
        addr_nxt = addr_r;
        wd_nxt = wd_r;
        rdata_nxt = rdata_r;
        doe_nxt = doe_r;
        is_wr_nxt = is_wr_r;
        seen_nxt = seen_r;
        sep_nxt = sep_r;
        done_nxt = 1'b0;
        gap_nxt = gap_r;
        unique case (state_r)
            H_IDLE: begin
                if (req) begin
                    sep_nxt = (mode_sel == `PHBP_MODE_SEP);
                    addr_nxt = req_addr;
                    wd_nxt = req_wdata;
                    doe_nxt = req_write;
                    is_wr_nxt = req_write;
                    wr_n_nxt = (mode_sel == `PHBP_MODE_SEP) ? 1'b1 : ~req_write;
                    seen_nxt = 1'b0;
                    state_nxt = H_SETUP;
                end
            end
            H_SETUP: begin
                cs_n_nxt = 1'b0;
                state_nxt = sep_r ? H_STROBE : H_WAIT;
            end
            H_STROBE: begin
                wr_n_nxt = ~is_wr_r;
                rd_n_nxt = is_wr_r;
                state_nxt = H_WAIT;
            end
            H_WAIT: begin
                if (bus.ack_line == ~sep_r) begin
                    seen_nxt = 1'b1;
                end
                if (seen_r && bus.ack_line == sep_r) begin
                    rdata_nxt = bus.data_bus;
                    state_nxt = H_RELEASE;
                end
            end
            H_RELEASE: begin
                if (sep_r) begin
                    wr_n_nxt = 1'b1;
                    rd_n_nxt = 1'b1;
                end else begin
                    cs_n_nxt = 1'b1;
                end
                state_nxt = H_END;
            end
            H_END: begin
                // Data outlives the edge that ends the access by one cycle
                doe_nxt = 1'b0;
                cs_n_nxt = 1'b1;
                wr_n_nxt = 1'b1;
                done_nxt = 1'b1;
                gap_nxt = is_wr_r ? 6'(`PHBP_GAP_WR_CYC)
                    : 6'(`PHBP_GAP_RD_CYC);
                state_nxt = H_GAP;
            end
            H_GAP: begin
                if (gap_r > 6'h01) begin
                    gap_nxt = gap_r - 6'h01;
                end else begin
                    state_nxt = H_IDLE;
                end
            end
            default: state_nxt = H_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r <= H_IDLE;
            cs_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            addr_r <= '0;
            wd_r <= '0;
            rdata_r <= '0;
            doe_r <= 1'b0;
            is_wr_r <= 1'b0;
            seen_r <= 1'b0;
            sep_r <= 1'b0;
            done_r <= 1'b0;
            gap_r <= 6'h00;
        end else begin
            state_r <= state_nxt;
            cs_n_r <= cs_n_nxt;
            wr_n_r <= wr_n_nxt;
            rd_n_r <= rd_n_nxt;
            addr_r <= addr_nxt;
            wd_r <= wd_nxt;
            rdata_r <= rdata_nxt;
            doe_r <= doe_nxt;
            is_wr_r <= is_wr_nxt;
            seen_r <= seen_nxt;
            sep_r <= sep_nxt;
            done_r <= done_nxt;
            gap_r <= gap_nxt;
        end
    end

    logic idle_r;
    // Idle flag registered so the output comes from a flop
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            idle_r <= 1'b1;
        end else begin
            idle_r <= (state_nxt == H_IDLE);
        end
    end

    assign bus.chip_select_n = cs_n_r;
    assign bus.write_strobe_n = wr_n_r;
    assign bus.read_strobe_n = rd_n_r;
    assign bus.addr = addr_r;
    assign bus.data_h2d = wd_r;
    assign bus.data_h2d_oe = doe_r;
    assign idle = idle_r;
    assign done = done_r;
    assign rdata = rdata_r;
endmodule

`default_nettype wire

//--- phbp_if.sv
// Pin bundle between the host and the device port.
// The shared data bus and the acknowledge line are resolved here from the enables;
// an undriven line reads as pulled high.
`timescale 1ns/1ps
`default_nettype none

interface phbp_if;
    import phbp_pkg::*;
    logic chip_select_n;
    logic write_strobe_n;
    logic read_strobe_n;
    phbp_addr_t addr;
    phbp_data_t data_h2d;
    logic data_h2d_oe;
    phbp_data_t data_d2h;
    logic data_d2h_oe;
    logic transfer_acknowledge;
    logic transfer_acknowledge_oe;
    phbp_data_t data_bus;
    logic ack_line;

    // Wire resolution with pull-ups
    assign data_bus = data_d2h_oe ? data_d2h : (data_h2d_oe ? data_h2d : '1);
    assign ack_line = transfer_acknowledge_oe ? transfer_acknowledge : 1'b1;

    modport dev (
        input chip_select_n, write_strobe_n, read_strobe_n, addr, data_bus,
        output data_d2h, data_d2h_oe, transfer_acknowledge, transfer_acknowledge_oe
    );
    modport host (
        input data_bus, ack_line,
        output chip_select_n, write_strobe_n, read_strobe_n, addr, data_h2d, data_h2d_oe
    );
endinterface

`default_nettype wire

//--- phbp_pkg.sv
// Types shared by both ends of the parallel host bus port.
// Assumes phbp_defines.svh is on the include path.
`include "phbp_defines.svh"

package phbp_pkg;
    typedef logic [`PHBP_ADDR_W-1:0] phbp_addr_t;
    typedef logic [`PHBP_DATA_W-1:0] phbp_data_t;
    typedef logic [`PHBP_MODE_W-1:0] phbp_mode_t;
    typedef enum logic [1:0] {D_IDLE, D_ARMED, D_WAIT, D_HOLD} phbp_dev_state_t;
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_WAIT, H_RELEASE, H_END, H_GAP}
        phbp_host_state_t;
endpackage

//--- phbp_sva.sv
// Checker for the pins between the host end and the device end of the host bus port.
// Assumes the bench wires it beside the pin bundle, on the core clock and reset.
`timescale 1ns/1ps
`default_nettype none

module phbp_sva (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // Host drives
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic data_h2d_oe,
    // Device drives
    input wire logic data_d2h_oe,
    input wire logic transfer_acknowledge,
    input wire logic transfer_acknowledge_oe
);
    // ****
    // Stretch counters
    // ****
    logic [7:0] hi_cnt_r, hi_cnt_nxt, lo_cnt_r, lo_cnt_nxt;
    logic cs_q_r, cur_wr_r, cur_wr_nxt, prev_wr_r, prev_wr_nxt;
    logic ack_hi, ack_lo, sel_rd;

    // Counts run only inside one access, so a long idle never trips them
    assign ack_hi = !chip_select_n && transfer_acknowledge_oe && transfer_acknowledge;
    assign ack_lo = !chip_select_n && transfer_acknowledge_oe && !transfer_acknowledge
        && !(read_strobe_n && write_strobe_n);
    assign sel_rd = !chip_select_n && read_strobe_n && write_strobe_n;

    // The previous access decides which stretch limit applies
    always_comb begin
        hi_cnt_nxt = ack_hi ? hi_cnt_r + 8'h01 : 8'h00;
        lo_cnt_nxt = ack_lo ? lo_cnt_r + 8'h01 : 8'h00;
        cur_wr_nxt = cur_wr_r | (!chip_select_n & !write_strobe_n);
        prev_wr_nxt = prev_wr_r;
        if (chip_select_n && !cs_q_r) begin
            prev_wr_nxt = cur_wr_r;
            cur_wr_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            hi_cnt_r <= 8'h00;
            lo_cnt_r <= 8'h00;
            cs_q_r <= 1'b1;
            cur_wr_r <= 1'b0;
            prev_wr_r <= 1'b0;
        end else begin
            hi_cnt_r <= hi_cnt_nxt;
            lo_cnt_r <= lo_cnt_nxt;
            cs_q_r <= chip_select_n;
            cur_wr_r <= cur_wr_nxt;
            prev_wr_r <= prev_wr_nxt;
        end
    end

    // ****
    // Properties
    // ****
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_ack_in_access: assert property ($rose(transfer_acknowledge_oe) |-> !chip_select_n)
        else $error("ready driven outside an access");
    a_ack_answers: assert property ($fell(chip_select_n) |-> ##[2:10] ack_hi)
        else $error("no ready after select");
    a_ack_released: assert property ($rose(chip_select_n) |-> ##[1:8] !transfer_acknowledge_oe)
        else $error("ready not released");
    // A counter of N means N+1 cycles of 5 ns, so each limit is floor(ns / 5) - 1
    a_high_max: assert property (ack_hi |-> hi_cnt_r <= 8'h23)
        else $error("ready high too long");
    a_high_wr: assert property (ack_hi && !write_strobe_n |-> hi_cnt_r <= 8'h20)
        else $error("write ready high too long");
    a_high_rr: assert property (ack_hi && sel_rd && !prev_wr_r |-> hi_cnt_r <= 8'h08)
        else $error("read ready high too long");
    a_low_max: assert property (ack_lo |-> lo_cnt_r <= 8'h23)
        else $error("ready low too long");
    a_low_rr: assert property (ack_lo && !read_strobe_n && !prev_wr_r
        |-> lo_cnt_r <= 8'h08)
        else $error("read ready low too long");
    a_ack_low_holds: assert property (sel_rd && transfer_acknowledge_oe && !transfer_acknowledge
        |=> !transfer_acknowledge || !transfer_acknowledge_oe)
        else $error("ready rose again in access");
    a_no_bus_fight: assert property (!(data_d2h_oe && data_h2d_oe))
        else $error("both ends drive data");

    c_sel_read: cover property (sel_rd && $fell(transfer_acknowledge));
    c_sep_read: cover property (!read_strobe_n && $rose(transfer_acknowledge));
    c_write: cover property (!write_strobe_n && $rose(chip_select_n));
endmodule

`default_nettype wire
